// >>> inc/pcs_pkg.sv
// package for the transceiver control and status register pair
package pcs_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0]  CTRL_IDX        = 8'h10;
    localparam logic [7:0]  STAT_IDX        = 8'h11;
    localparam logic [11:0] CTRL_ADDR       = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [11:0] STAT_ADDR       = {2'h0, STAT_IDX, 2'h0};
    localparam logic [15:0] CTRL_RESET      = 16'h5048;
    localparam logic [15:0] STAT_RESET      = 16'h0000;
    // control field positions
    localparam int CTRL_TXD_LSB    = 14;
    localparam int CTRL_RXD_LSB    = 12;
    localparam int CTRL_FORCE_BIT  = 10;
    localparam int CTRL_PWR_LSB    = 8;
    localparam int CTRL_SWAP_LSB   = 5;
    localparam int CTRL_CLKOFF_BIT = 4;
    localparam int CTRL_INV_BIT    = 1;
    localparam int CTRL_JABOFF_BIT = 0;
    // status field positions
    localparam int STAT_SPEED_LSB  = 14;
    localparam int STAT_DUPLEX_BIT = 13;
    localparam int STAT_PAGE_BIT   = 12;
    localparam int STAT_RESOLV_BIT = 11;
    localparam int STAT_LINK_BIT   = 10;
    localparam int STAT_CD_BIT     = 9;
    localparam int STAT_AB_BIT     = 8;
    localparam int STAT_DSHIFT_BIT = 7;
    localparam int STAT_SLEEP_BIT  = 6;
    localparam int STAT_POL_LSB    = 2;
    localparam int STAT_POL10_BIT  = 1;
    localparam int STAT_JAB_BIT    = 0;
    // speed codes
    localparam logic [1:0] SPEED_10   = 2'h0;
    localparam logic [1:0] SPEED_100  = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;
    // power-save codes
    localparam logic [1:0] PWR_NORMAL  = 2'h0;
    localparam logic [1:0] PWR_ACTIVE  = 2'h2;
    localparam logic [1:0] PWR_PASSIVE = 2'h3;
    // crossover codes
    localparam logic [1:0] SWAP_MDI  = 2'h0;
    localparam logic [1:0] SWAP_MDIX = 2'h1;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // live state reported by the transceiver core
    typedef struct packed {
        logic [1:0] speed;
        logic       duplex_full;
        logic       page_event;
        logic       an_resolved;
        logic       link_qualified;
        logic       swap_cd;
        logic       swap_ab;
        logic       downshift_active;
        logic       asleep;
        logic [3:0] pair_polarity_bits;
        logic       pol10_normal;
        logic       runaway_tx_seen;
    } pcs_core_stat_t;

    // decoded control for the transceiver core
    typedef struct packed {
        logic [1:0] tx_depth_code;
        logic [3:0] tx_depth_bytes;
        logic       tx_buf_active;
        logic [1:0] rx_depth_code;
        logic [3:0] rx_depth_bytes;
        logic       rx_buf_active;
        logic       sleep_active;
        logic       sleep_passive;
        logic       swap_manual_mdix;
        logic       swap_auto;
        logic       ref_clock_output_en;
        logic       driver_invert;
        logic       jabber_enable;
    } pcs_core_ctrl_t;
endpackage

// >>> logic/pcs_regs.sv
// control and status register pair of the transceiver, axi4-lite slave
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
module pcs_regs (
    // clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // axi4-lite write address
    input  wire logic [11:0]             s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0]             s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // straps and operating mode
    input  wire logic [1:0]              strap_swap_mode,
    input  wire logic                    mode_gmii,
    input  wire logic                    mode_sgmii,
    input  wire logic                    mode_mirror,
    // core side
    input  wire pcs_pkg::pcs_core_stat_t core_stat,
    output pcs_pkg::pcs_core_ctrl_t      core_ctrl,
    output logic                         link_ok
);

    // depth code to buffer length in bytes or nibbles
    function automatic logic [3:0] depth_of(input logic [1:0] code);
        case (code)
            2'h0:    depth_of = 4'h3;
            2'h1:    depth_of = 4'h4;
            2'h2:    depth_of = 4'h6;
            default: depth_of = 4'h8;
        endcase
    endfunction

    // word-aligned address match
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] r);
        hit = (a[11:2] == r[11:2]);
    endfunction

    typedef enum logic [1:0] {
        PCS_W_IDLE = 2'b00,
        PCS_W_RESP = 2'b01
    } pcs_wr_state_t;

    pcs_wr_state_t wr_state_ff;
    logic [11:0]   awaddr_ff;
    logic          aw_held_ff;
    logic [31:0]   wdata_ff;
    logic [3:0]    wstrb_ff;
    logic          w_held_ff;
    logic [1:0]    bresp_ff;
    logic          rvalid_ff;
    logic [31:0]   rdata_ff;
    logic [1:0]    rresp_ff;
    logic [15:0]   ctrl_ff;
    logic          strap_pending_ff;
    logic          page_ff;
    logic          wr_fire;
    logic          rd_fire;
    logic          stat_read;
    logic          force_good;
    logic [15:0]   stat_word;
    logic [15:0]   nxt_ctrl;

    // address and data are taken independently, either order
    assign s_axi_awready = (wr_state_ff == PCS_W_IDLE) && !aw_held_ff;
    assign s_axi_wready  = (wr_state_ff == PCS_W_IDLE) && !w_held_ff;
    assign wr_fire       = (wr_state_ff == PCS_W_IDLE)
                           && aw_held_ff && w_held_ff;
    assign s_axi_bvalid  = (wr_state_ff == PCS_W_RESP);
    assign s_axi_bresp   = bresp_ff;

    // capture write address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
        end
    end

    // capture write data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_ff <= 1'b0;
        end
    end

    // write response state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= PCS_W_IDLE;
            bresp_ff    <= pcs_pkg::RESP_OKAY;
        end else begin
            case (wr_state_ff)
                PCS_W_IDLE: begin
                    if (wr_fire) begin
                        wr_state_ff <= PCS_W_RESP;
                        // status is read-only, so a write there is an error
                        if (hit(awaddr_ff, pcs_pkg::CTRL_ADDR)) begin
                            bresp_ff <= pcs_pkg::RESP_OKAY;
                        end else begin
                            bresp_ff <= pcs_pkg::RESP_SLVERR;
                        end
                    end
                end
                PCS_W_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_ff <= PCS_W_IDLE;
                    end
                end
                default: wr_state_ff <= PCS_W_IDLE;
            endcase
        end
    end

    // byte-lane merge into the control word; upper lanes are void
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wstrb_ff[0]) begin
            nxt_ctrl[7:0] = wdata_ff[7:0];
        end
        if (wstrb_ff[1]) begin
            nxt_ctrl[15:8] = wdata_ff[15:8];
        end
    end

    // control word; crossover field follows the strap after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff          <= pcs_pkg::CTRL_RESET;
            strap_pending_ff <= 1'b1;
        end else if (wr_fire && hit(awaddr_ff, pcs_pkg::CTRL_ADDR)) begin
            ctrl_ff          <= nxt_ctrl;
            strap_pending_ff <= 1'b0;
        end else if (strap_pending_ff) begin
            // strap caught clocked, first edge after release
            ctrl_ff[pcs_pkg::CTRL_SWAP_LSB +: 2] <= strap_swap_mode;
            strap_pending_ff <= 1'b0;
        end
    end

    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !rvalid_ff;
    assign stat_read     = rd_fire && hit(s_axi_araddr, pcs_pkg::STAT_ADDR);

    // page flag: arrival wins over a clearing read in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page_ff <= 1'b0;
        end else if (core_stat.page_event) begin
            page_ff <= 1'b1;
        end else if (stat_read) begin
            page_ff <= 1'b0;
        end
    end

    // 1G forced link overrides qualification only at gigabit speed
    assign force_good = ctrl_ff[pcs_pkg::CTRL_FORCE_BIT]
                        && (core_stat.speed == pcs_pkg::SPEED_1000);

    // status word: live fields plus the latched page flag and registered link_ok
    always_comb begin
        stat_word = pcs_pkg::STAT_RESET;
        stat_word[pcs_pkg::STAT_SPEED_LSB +: 2] = core_stat.speed;
        stat_word[pcs_pkg::STAT_DUPLEX_BIT] = core_stat.duplex_full;
        stat_word[pcs_pkg::STAT_PAGE_BIT]   = page_ff;
        stat_word[pcs_pkg::STAT_RESOLV_BIT] = core_stat.an_resolved;
        stat_word[pcs_pkg::STAT_LINK_BIT]   = link_ok;
        stat_word[pcs_pkg::STAT_CD_BIT]     = core_stat.swap_cd;
        stat_word[pcs_pkg::STAT_AB_BIT]     = core_stat.swap_ab;
        stat_word[pcs_pkg::STAT_DSHIFT_BIT] =
            core_stat.downshift_active;
        stat_word[pcs_pkg::STAT_SLEEP_BIT]  = core_stat.asleep;
        stat_word[pcs_pkg::STAT_POL_LSB +: 4] =
            core_stat.pair_polarity_bits;
        stat_word[pcs_pkg::STAT_POL10_BIT]  = core_stat.pol10_normal;
        stat_word[pcs_pkg::STAT_JAB_BIT]    =
            core_stat.runaway_tx_seen;
    end

    // read channel, one outstanding read; rdata registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= pcs_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_ff <= 1'b1;
            if (hit(s_axi_araddr, pcs_pkg::CTRL_ADDR)) begin
                rdata_ff <= {16'h0000, ctrl_ff};
                rresp_ff <= pcs_pkg::RESP_OKAY;
            end else if (stat_read) begin
                rdata_ff <= {16'h0000, stat_word};
                rresp_ff <= pcs_pkg::RESP_OKAY;
            end else begin
                rdata_ff <= 32'h0000_0000;
                rresp_ff <= pcs_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // link indication to the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_ok <= 1'b0;
        end else begin
            link_ok <= core_stat.link_qualified || force_good;
        end
    end

    // decoded control, registered so the core sees clean levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_ctrl <= '0;
        end else begin
            core_ctrl.tx_depth_code  <= ctrl_ff[pcs_pkg::CTRL_TXD_LSB +: 2];
            core_ctrl.tx_depth_bytes <=
                depth_of(ctrl_ff[pcs_pkg::CTRL_TXD_LSB +: 2]);
            // transmit buffer only for 1G with gmii, or any speed with sgmii
            core_ctrl.tx_buf_active  <= mode_sgmii || (mode_gmii
                && core_stat.speed == pcs_pkg::SPEED_1000);
            core_ctrl.rx_depth_code  <= ctrl_ff[pcs_pkg::CTRL_RXD_LSB +: 2];
            core_ctrl.rx_depth_bytes <=
                depth_of(ctrl_ff[pcs_pkg::CTRL_RXD_LSB +: 2]);
            core_ctrl.rx_buf_active  <= mode_sgmii;
            // reserved code 1 behaves as normal operation
            core_ctrl.sleep_active   <= (ctrl_ff[pcs_pkg::CTRL_PWR_LSB +: 2]
                == pcs_pkg::PWR_ACTIVE);
            core_ctrl.sleep_passive  <= (ctrl_ff[pcs_pkg::CTRL_PWR_LSB +: 2]
                == pcs_pkg::PWR_PASSIVE);
            core_ctrl.swap_manual_mdix <=
                (ctrl_ff[pcs_pkg::CTRL_SWAP_LSB +: 2]
                == pcs_pkg::SWAP_MDIX);
            core_ctrl.swap_auto      <=
                ctrl_ff[pcs_pkg::CTRL_SWAP_LSB + 1];
            core_ctrl.ref_clock_output_en <=
                !ctrl_ff[pcs_pkg::CTRL_CLKOFF_BIT];
            // inversion is ignored while mirroring
            core_ctrl.driver_invert  <= ctrl_ff[pcs_pkg::CTRL_INV_BIT]
                && !mode_mirror;
            core_ctrl.jabber_enable  <=
                !ctrl_ff[pcs_pkg::CTRL_JABOFF_BIT];
        end
    end

endmodule // pcs_regs

// >>> dv/pcs_regs_chk.sv
// concurrent checks on the register pair ports
`timescale 1ns/1ns
module pcs_regs_chk (
    // clock and reset
    input wire logic                    aclk,
    input wire logic                    aresetn,
    // register bus
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic                    s_axi_bvalid,
    input wire logic [11:0]             s_axi_araddr,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic [1:0]              s_axi_rresp,
    input wire logic                    s_axi_rvalid,
    // core side
    input wire logic                    mode_sgmii,
    input wire pcs_pkg::pcs_core_stat_t core_stat,
    input wire pcs_pkg::pcs_core_ctrl_t core_ctrl,
    input wire logic                    link_ok
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic ok_rd;
    // mapped read decode, looked at one cycle later
    assign ok_rd = s_axi_araddr == pcs_pkg::CTRL_ADDR
                || s_axi_araddr == pcs_pkg::STAT_ADDR;
    // depth in bytes for each code
    function automatic logic [3:0] dep(input logic [1:0] c);
        return c[1] ? (c[0] ? 4'h8 : 4'h6) : (c[0] ? 4'h4 : 4'h3);
    endfunction
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_read_answer: assert property (
        s_ar_take |=> s_axi_rvalid && s_axi_rresp == ($past(ok_rd)
            ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR))
        else $error("read answer late or wrong response");
    a_unmapped_zero: assert property (
        s_ar_take and !ok_rd |=> s_axi_rdata == 32'h0)
        else $error("unmapped read returned data");
    a_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read half not zero");
    a_write_answer: assert property (
        s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two cycles after take");
    a_ar_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while answering");
    a_write_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel accepted while answering");
    // page flag and link bit are left out: latched or forced
    a_status_live: assert property (
        s_ar_take and s_axi_araddr == pcs_pkg::STAT_ADDR |=>
        {s_axi_rdata[15:13], s_axi_rdata[11], s_axi_rdata[9:0]} ==
        $past({core_stat[15:13], core_stat[11], core_stat[9:0]}))
        else $error("status word does not track core state");
    a_link_up: assert property (
        core_stat.link_qualified |=> link_ok)
        else $error("link up not reported");
    a_link_down: assert property (
        !core_stat.link_qualified && core_stat.speed != 2'h2 |=> !link_ok)
        else $error("link reported without cause");
    a_depth_codes: assert property (
        $past(aresetn) |-> core_ctrl.tx_depth_bytes ==
        dep(core_ctrl.tx_depth_code) && core_ctrl.rx_depth_bytes ==
        dep(core_ctrl.rx_depth_code))
        else $error("buffer depth decode wrong");
    a_rx_sgmii: assert property (
        $stable(mode_sgmii) && !mode_sgmii |-> !core_ctrl.rx_buf_active)
        else $error("receive buffer active without sgmii");
endmodule // pcs_regs_chk

bind pcs_regs pcs_regs_chk i_chk (.*);

// >>> dv/pcs_host.sv
// management host model on the axi4-lite register bus
`timescale 1ns/1ns
module pcs_host (
    // clock
    input wire logic        aclk,
    // write channels
    output logic [11:0]     s_axi_awaddr,
    output logic            s_axi_awvalid,
    input wire logic        s_axi_awready,
    output logic [31:0]     s_axi_wdata,
    output logic [3:0]      s_axi_wstrb,
    output logic            s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    output logic            s_axi_bready,
    // read channels
    output logic [11:0]     s_axi_araddr,
    output logic            s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    output logic            s_axi_rready
);
    // idle bus from time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 28'h0;
        s_axi_wdata = 32'h0;
    end
    // released payload is inverted so stale values never match
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        fork
            begin
                do @(posedge aclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            begin
                do @(posedge aclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // read waits on the slave, no fixed latency assumed
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule // pcs_host

// >>> dv/pcs_regs_bench.sv
// self-checking bench for the control and status register pair
`timescale 1ns/1ns
module pcs_regs_bench;
    localparam logic [11:0] CA = pcs_pkg::CTRL_ADDR;
    localparam logic [11:0] SA = pcs_pkg::STAT_ADDR;
    localparam logic [1:0]  OK = pcs_pkg::RESP_OKAY;
    localparam logic [1:0]  ER = pcs_pkg::RESP_SLVERR;
    logic                    aclk, aresetn, link_ok;
    logic                    mode_gmii, mode_sgmii, mode_mirror;
    logic [1:0]              strap_swap_mode, resp, k;
    logic [11:0]             s_axi_awaddr, s_axi_araddr;
    logic [31:0]             s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0]              s_axi_wstrb;
    logic [1:0]              s_axi_bresp, s_axi_rresp;
    logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                    s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                    s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic                    s_axi_rready;
    logic [15:0]             cw, p;
    pcs_pkg::pcs_core_stat_t core_stat;
    pcs_pkg::pcs_core_ctrl_t core_ctrl;
    int                      fail_count = 0, check_count = 0, cyc = 0;
    logic [3:0]              dep [4] = '{4'h3, 4'h4, 4'h6, 4'h8};

    pcs_regs i_dut (.*);
    pcs_host i_host (.*);

    // 125 MHz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic rst(input logic [1:0] s);
        strap_swap_mode <= s;
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic w(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
        i_host.wr(a, d, s, resp);
        chk(resp, er);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        i_host.rd(a, rdv, resp);
        chk(rdv, e);
        chk(resp, er);
    endtask
    // decoded control expected from a control word and the live modes
    function automatic pcs_pkg::pcs_core_ctrl_t want(input logic [15:0] v);
        pcs_pkg::pcs_core_ctrl_t e;
        e.tx_depth_code = v[15:14];
        e.tx_depth_bytes = dep[v[15:14]];
        e.tx_buf_active = mode_sgmii | (mode_gmii & core_stat.speed == 2'h2);
        e.rx_depth_code = v[13:12];
        e.rx_depth_bytes = dep[v[13:12]];
        e.rx_buf_active = mode_sgmii;
        e.sleep_active = v[9:8] == 2'h2;
        e.sleep_passive = v[9:8] == 2'h3;
        e.swap_manual_mdix = v[6:5] == 2'h1;
        e.swap_auto = v[6];
        e.ref_clock_output_en = !v[4];
        e.driver_invert = v[1] & !mode_mirror;
        e.jabber_enable = !v[0];
        return e;
    endfunction

    initial begin
        aresetn = 1'b0;
        strap_swap_mode = 2'h2;
        {mode_gmii, mode_sgmii, mode_mirror} = 3'h4;
        core_stat = '0;
        rst(2'h2);
        rc(CA, 32'h5048, OK);
        chk(core_ctrl, want(16'h5048));
        rc(SA, 32'h0, OK);
        // every code of each field, upper lanes written and ignored
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            cw = {k, k, 1'b0, k[1], k, k[0], k, k[0], k, k[0], k[1]};
            // gmii seen on and off with and without 1G; sgmii on only without 1G
            mode_sgmii <= k == 2'h2;
            mode_gmii <= !k[1];
            mode_mirror <= k == 2'h3;
            core_stat.speed <= k[0] ? 2'h2 : 2'h1;
            w(CA, {16'hffff, cw}, 4'hf, OK);
            rc(CA, {16'h0, cw}, OK);
            chk(core_ctrl, want(cw));
            chk(link_ok, k == 2'h3);
            rc(SA, {k[0], !k[0], 3'h0, k == 2'h3, 10'h0}, OK);
        end
        // byte lanes, read-only and unmapped places
        w(CA, 32'h5048, 4'hf, OK);
        w(CA, 32'h00b7, 4'h1, OK);
        w(CA, 32'hffffffff, 4'hc, OK);
        rc(CA, 32'h50b7, OK);
        w(SA, 32'hffff, 4'hf, ER);
        w(12'h48, 32'h0, 4'hf, ER);
        rc(12'h48, 32'h0, ER);
        // live status patterns, force bit now clear
        for (int i = 0; i < 2; i++) begin
            p = i ? 16'h4a5a : 16'ha5a5;
            core_stat <= p;
            rc(SA, p, OK);
            chk(link_ok, p[10]);
            chk(rdv[7:0], p[7:0]);
        end
        // page event latches until the status read clears it
        @(posedge aclk) core_stat.page_event <= 1'b1;
        @(posedge aclk) core_stat.page_event <= 1'b0;
        repeat (3) @(posedge aclk);
        rc(SA, 32'h5a5a, OK);
        rc(SA, 32'h4a5a, OK);
        // strap sets the crossover reset value, four more resets mid-run
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            rst(k);
            rc(CA, {16'h5008, 16'h0} >> 16 | {25'h0, k, 5'h0}, OK);
            chk(core_ctrl, want(16'h5008 | {9'h0, k, 5'h0}));
        end
        wrap_up();
    end
endmodule // pcs_regs_bench
